/* src/jufl_map.vh */
// constants for the jump and unary flag execute block
// Behaviour
// - after irq unmask, next instruction always executes before any interrupt is taken.
// - increment sets zero and carry only when operand was all ones.
// - increment sets overflow only when operand was largest positive value.
// - increment and invert take negative flag from result sign bit.
// - invert writes bitwise complement of destination, original value lost.
// - invert sets zero only when operand was all ones.
// - invert carry is complement of zero flag.
// - invert sets overflow when original operand was negative.
// - unary operations leave oscillator, halt and global irq bits unchanged.
// - taken jump adds twice signed 10-bit offset; else next instruction.
// - unconditional jump always applies offset without testing flags.
// - carry jump taken when carry is one.
// - no-carry jump taken when carry is zero.
// - equal jump taken when zero flag is one.
// - signed greater-or-equal taken when negative equals overflow.
// - signed less taken when negative differs from overflow.
// - negative jump taken when negative flag is one.
// - jumps never modify negative, zero, carry or overflow flags.
`ifndef JUFL_MAP_VH
`define JUFL_MAP_VH
// ------------------------------
// status register bit positions
// ------------------------------
`define JUFL_SR_C 0
`define JUFL_SR_Z 1
`define JUFL_SR_N 2
`define JUFL_SR_IRQ_ALLOW 3
`define JUFL_SR_CORE_HALT 4
`define JUFL_SR_OSC_STOP 5
`define JUFL_SR_V 8
`define JUFL_SR_RESET 16'h0000
`define JUFL_PC_RESET 16'h0000
// ------------------------------
// operation codes
// ------------------------------
`define JUFL_OP_NONE 4'h0
`define JUFL_OP_INC 4'h1
`define JUFL_OP_ADD2 4'h2
`define JUFL_OP_NOT 4'h3
`define JUFL_OP_UNMASK 4'h4
`define JUFL_OP_JUMP 4'h5
`define JUFL_OP_OTHER 4'h6
// ------------------------------
// jump condition codes (instruction bits 12:10)
// ------------------------------
`define JUFL_CC_NZ 3'h0
`define JUFL_CC_Z 3'h1
`define JUFL_CC_NC 3'h2
`define JUFL_CC_C 3'h3
`define JUFL_CC_N 3'h4
`define JUFL_CC_GE 3'h5
`define JUFL_CC_L 3'h6
`define JUFL_CC_ALWAYS 3'h7
`define JUFL_OFS_MSB 9
`define JUFL_INSTR_BYTES 16'h0002
`endif

/* src/jufl_cond.v */
// jump condition evaluator
`include "jufl_map.vh"
module jufl_cond (
  input wire [2:0] cond_code, // condition field
  input wire [15:0] sr_in, // status word
  output reg taken // condition true
);
  wire c = sr_in[`JUFL_SR_C];
  wire z = sr_in[`JUFL_SR_Z];
  wire n = sr_in[`JUFL_SR_N];
  wire v = sr_in[`JUFL_SR_V];
  always @* begin
    case (cond_code)
      `JUFL_CC_NZ: taken = ~z;
      `JUFL_CC_Z: taken = z;
      `JUFL_CC_NC: taken = ~c;
      `JUFL_CC_C: taken = c;
      `JUFL_CC_N: taken = n;
      `JUFL_CC_GE: taken = ~(n ^ v);
      `JUFL_CC_L: taken = n ^ v;
      `JUFL_CC_ALWAYS: taken = 1'b1;
      default: taken = 1'b0;
    endcase
  end
endmodule

/* src/jufl_exec.v */
// execute stage slice: unary ops, relative jumps, irq unmask delay
`include "jufl_map.vh"
module jufl_exec (
  input wire clk_sys, // system clock
  input wire reset, // sync reset, active high
  input wire op_valid, // instruction issued this cycle
  input wire [3:0] op_code, // operation select
  input wire byte_mode, // byte form
  input wire [15:0] instr_word, // instruction word
  input wire [15:0] dst_in, // destination operand
  input wire irq_pending, // interrupt request from controller
  input wire sr_load, // external status write
  input wire [15:0] sr_load_val, // external status value
  input wire pc_load, // external pc write
  input wire [15:0] pc_load_val, // external pc value
  output reg [15:0] result_out, // unary result
  output reg result_valid, // result written this cycle
  output wire [15:0] sr_out, // status register
  output wire [15:0] pc_out, // program counter
  output reg jump_taken, // last jump was taken
  output wire irq_accept // interrupt may be taken now
);
  // ------------------------------
  // state
  // ------------------------------
  reg [15:0] sr_reg;
  reg [15:0] sr_next;
  reg [15:0] pc_reg;
  reg [15:0] pc_next;
  reg hold_reg;
  reg hold_next;
  reg [15:0] res_next;
  wire cond_true;

  assign sr_out = sr_reg;
  assign pc_out = pc_reg;

  // ------------------------------
  // helpers
  // ------------------------------
  function [15:0] sext_ofs2;
    input [9:0] ofs;
    begin
      sext_ofs2 = {{5{ofs[`JUFL_OFS_MSB]}}, ofs, 1'b0};
    end
  endfunction

  function sign_of;
    input [15:0] val;
    input bm;
    begin
      sign_of = bm ? val[7] : val[15];
    end
  endfunction

  function [15:0] width_mask;
    input bm;
    begin
      width_mask = bm ? 16'h00ff : 16'hffff;
    end
  endfunction

  jufl_cond u_cond (
    .cond_code(instr_word[12:10]),
    .sr_in(sr_reg),
    .taken(cond_true)
  );

  // ------------------------------
  // datapath
  // ------------------------------
  reg [15:0] opd;
  reg [15:0] msk;
  reg [15:0] maxpos;
  always @* begin
    sr_next = sr_reg;
    pc_next = pc_reg;
    res_next = result_out;
    hold_next = 1'b0;
    msk = width_mask(byte_mode);
    opd = dst_in & msk;
    maxpos = msk >> 1;
    if (op_valid) begin
      pc_next = pc_reg + `JUFL_INSTR_BYTES;
      case (op_code)
        `JUFL_OP_INC: begin
          res_next = (opd + 16'h0001) & msk;
          sr_next[`JUFL_SR_Z] = (opd == msk);
          sr_next[`JUFL_SR_C] = (opd == msk);
          sr_next[`JUFL_SR_V] = (opd == maxpos);
          sr_next[`JUFL_SR_N] = sign_of(res_next, byte_mode);
        end
        `JUFL_OP_ADD2: begin
          res_next = (opd + 16'h0002) & msk;
          sr_next[`JUFL_SR_Z] = (res_next == 16'h0000);
          sr_next[`JUFL_SR_C] = (opd == msk) || (opd == msk - 16'h0001);
          sr_next[`JUFL_SR_V] = (opd == maxpos) || (opd == maxpos - 16'h0001);
          sr_next[`JUFL_SR_N] = sign_of(res_next, byte_mode);
        end
        `JUFL_OP_NOT: begin
          res_next = (opd ^ msk);
          sr_next[`JUFL_SR_Z] = (opd == msk);
          sr_next[`JUFL_SR_C] = (opd != msk);
          sr_next[`JUFL_SR_V] = sign_of(opd, byte_mode);
          sr_next[`JUFL_SR_N] = sign_of(res_next, byte_mode);
        end
        `JUFL_OP_UNMASK: begin
          sr_next[`JUFL_SR_IRQ_ALLOW] = 1'b1;
          hold_next = 1'b1;
        end
        `JUFL_OP_JUMP: begin
          if (cond_true) begin
            pc_next = pc_reg + `JUFL_INSTR_BYTES + sext_ofs2(instr_word[9:0]);
          end
        end
        default: begin
          sr_next = sr_reg;
        end
      endcase
    end else begin
      hold_next = hold_reg;
    end
    if (sr_load) begin
      sr_next = sr_load_val;
    end
    if (pc_load) begin
      pc_next = pc_load_val;
    end
  end
  // unary ops touch only the arithmetic flag bits; unmask sets the irq allow bit and sr_load replaces the whole word

  // ------------------------------
  // interrupt gating
  // ------------------------------
  assign irq_accept = irq_pending & sr_reg[`JUFL_SR_IRQ_ALLOW] & ~hold_reg;

  // ------------------------------
  // registers
  // ------------------------------
  always @(posedge clk_sys) begin
    if (reset) begin
      sr_reg <= `JUFL_SR_RESET;
      pc_reg <= `JUFL_PC_RESET;
      hold_reg <= 1'b0;
      result_out <= 16'h0000;
      result_valid <= 1'b0;
      jump_taken <= 1'b0;
    end else begin
      sr_reg <= sr_next;
      pc_reg <= pc_next;
      hold_reg <= hold_next;
      result_out <= res_next;
      result_valid <= op_valid && (op_code == `JUFL_OP_INC || op_code == `JUFL_OP_ADD2 ||
                      op_code == `JUFL_OP_NOT);
      if (op_valid && op_code == `JUFL_OP_JUMP) begin
        jump_taken <= cond_true;
      end
    end
  end
endmodule

/* bench/jufl_props.sv */
// property checker for the execute slice
module jufl_props (
  input wire logic clk_sys, // system clock
  input wire logic reset, // sync reset, active high
  input wire logic op_valid, // op issued
  input wire logic byte_mode, // byte form
  input wire logic sr_load, // status write
  input wire logic pc_load, // pc write
  input wire logic jump_taken, // jump result
  input wire logic irq_accept, // irq gate
  input wire logic [3:0] op_code, // op select
  input wire logic [15:0] instr_word, // instruction
  input wire logic [15:0] dst_in, // operand
  input wire logic [15:0] result_out, // unary result
  input wire logic [15:0] sr_out, // status
  input wire logic [15:0] pc_out // program counter
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  wire go = op_valid && !sr_load && !pc_load;
  wire jump_go = go && op_code == 4'h5;
  wire [2:0] cc = instr_word[12:10];
  AST_JUMP_PC: assert property (jump_go |=> pc_out == $past(pc_out) + 16'h0002 +
    (jump_taken ? {{5{$past(instr_word[9])}}, $past(instr_word[9:0]), 1'b0} : 16'h0000))
    else $error("jump target wrong");
  AST_JUMP_ALWAYS: assert property (jump_go && cc == 3'h7 |=> jump_taken)
    else $error("unconditional jump not taken");
  AST_JUMP_CARRY: assert property (jump_go && cc == 3'h3 |=>
    jump_taken == $past(sr_out[0])) else $error("carry jump wrong");
  AST_JUMP_GE: assert property (jump_go && cc == 3'h5 |=>
    jump_taken == ($past(sr_out[2]) == $past(sr_out[8]))) else $error("signed ge jump wrong");
  AST_JUMP_FLAGS: assert property (jump_go |=> $stable({sr_out[8], sr_out[2:0]}))
    else $error("jump changed flags");
  AST_INC_FLAGS: assert property (go && op_code == 4'h1 && !byte_mode |=>
    sr_out[1:0] == {2{$past(dst_in) == 16'hffff}} && sr_out[8] == ($past(dst_in) == 16'h7fff))
    else $error("increment flags wrong");
  AST_NOT_RES: assert property (go && op_code == 4'h3 |=> sr_out[0] != sr_out[1] &&
    result_out == ($past(byte_mode) ? {8'h00, ~$past(dst_in[7:0])} : ~$past(dst_in)))
    else $error("invert result wrong");
  AST_MODE_KEEP: assert property (go && op_code inside {4'h1, 4'h2, 4'h3} |=>
    $stable(sr_out[5:3])) else $error("mode bits changed");
  AST_UNMASK: assert property (go && op_code == 4'h4 |=> sr_out[3] && !irq_accept)
    else $error("irq taken right after unmask");
  AST_UNMASK_IDLE: assert property (go && op_code == 4'h4 ##1 !op_valid |=> !irq_accept)
    else $error("irq taken before next instruction");
  cover property (jump_go && cc == 3'h7);
  cover property (go && op_code == 4'h4);
  cover property (go && op_code == 4'h2 && byte_mode);
endmodule

/* bench/tb_top.sv */
// self-checking bench for the execute slice
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, reset = 1, op_valid = 0, byte_mode = 0, irq_pending = 0;
  logic sr_load = 0, pc_load = 0, result_valid, jump_taken, irq_accept, t;
  logic [3:0] op_code = 0, f;
  logic [7:0] tk;
  logic [9:0] ofs;
  logic [15:0] instr_word = 0, dst_in = 0, sr_load_val = 0, pc_load_val = 0;
  logic [15:0] result_out, sr_out, pc_out, s, m;
  logic [16:0] x;
  logic [15:0] dv [7] = '{16'hffff, 16'h7fff, 16'hfffe, 16'h7ffe, 16'h00ff, 16'h807f, 16'h0000};
  int fail_count = 0, cmp_count = 0;
  always #12.5 clk_sys = ~clk_sys;
  jufl_exec u_jufl_exec (.clk_sys(clk_sys), .reset(reset), .op_valid(op_valid),
    .op_code(op_code), .byte_mode(byte_mode), .instr_word(instr_word), .dst_in(dst_in),
    .irq_pending(irq_pending), .sr_load(sr_load), .sr_load_val(sr_load_val),
    .pc_load(pc_load), .pc_load_val(pc_load_val), .result_out(result_out),
    .result_valid(result_valid), .sr_out(sr_out), .pc_out(pc_out),
    .jump_taken(jump_taken), .irq_accept(irq_accept));
  task chk(string n, logic [15:0] seen, logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task run(logic [3:0] op, logic bm, logic [15:0] iw, logic [15:0] d);
    @(negedge clk_sys);
    {op_valid, op_code, byte_mode, instr_word, dst_in} = {1'b1, op, bm, iw, d};
    @(negedge clk_sys);
    op_valid = 0;
  endtask
  task ld(logic [15:0] sv, logic [15:0] pv);
    @(negedge clk_sys);
    {sr_load, pc_load, sr_load_val, pc_load_val} = {2'b11, sv, pv};
    @(negedge clk_sys);
    {sr_load, pc_load} = 2'b00;
  endtask
  task test_done;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #50us;
    fail_count++;
    test_done;
  end
  initial begin
    repeat (20) @(negedge clk_sys);
    reset = 0;
    chk("sr reset", sr_out, 16'h0000);
    chk("pc reset", pc_out, 16'h0000);
    ld(16'h0038, 16'h0000);
    foreach (dv[i]) for (int k = 0; k < 6; k++) begin
      m = (k > 2) ? 16'h00ff : 16'hffff;
      x = (k % 3 == 2) ? {1'b0, ~dv[i] & m} : {1'b0, dv[i] & m} + ((k % 3 == 0) ? 17'h1 : 17'h2);
      s = x[15:0] & m;
      f[1] = (s == 16'h0000);
      f[2] = (k > 2) ? s[7] : s[15];
      f[0] = (k % 3 == 2) ? !f[1] : ((k > 2) ? x[8] : x[16]);
      f[3] = (k % 3 == 2) ? ((k > 2) ? dv[i][7] : dv[i][15]) : (!((k > 2) ? dv[i][7] : dv[i][15]) && f[2]);
      run(4'h1 + k % 3, k > 2, 16'h0000, dv[i]);
      chk("result", result_out, s);
      chk("flags", {sr_out[8], sr_out[2:0]}, f);
      chk("mode", sr_out[5:3], 3'b111);
      chk("valid", result_valid, 1'b1);
    end
    $display("unary test done");
    for (int i = 0; i < 128; i++) begin
      s = {7'h00, i[3], 5'h00, i[2:0]};
      ofs = i[0] ? 10'h200 : 10'h1ff;
      tk = {1'b1, s[2] ^ s[8], s[2] ~^ s[8], s[2], s[0], !s[0], s[1], !s[1]};
      t = tk[i[6:4]];
      ld(s, 16'h1000);
      run(4'h5, 1'b0, {3'b001, i[6:4], ofs}, 16'h0000);
      chk("taken", jump_taken, t);
      chk("pc", pc_out, 16'h1002 + (t ? {{5{ofs[9]}}, ofs, 1'b0} : 16'h0000));
      chk("jump sr", sr_out, s);
      chk("jump no result", result_valid, 1'b0);
    end
    $display("jump test done");
    ld(16'h0000, 16'h0000);
    irq_pending = 1;
    run(4'h4, 1'b0, 16'h0000, 16'h0000);
    chk("irq allow", sr_out[3], 1'b1);
    chk("held", irq_accept, 1'b0);
    @(negedge clk_sys);
    chk("held idle", irq_accept, 1'b0);
    run(4'h0, 1'b0, 16'h0000, 16'h0000);
    chk("accept", irq_accept, 1'b1);
    $display("unmask test done");
    test_done;
  end
endmodule
bind jufl_exec jufl_props u_jufl_props (.clk_sys(clk_sys), .reset(reset), .op_valid(op_valid),
  .byte_mode(byte_mode), .sr_load(sr_load), .pc_load(pc_load), .jump_taken(jump_taken),
  .irq_accept(irq_accept), .op_code(op_code), .instr_word(instr_word), .dst_in(dst_in),
  .result_out(result_out), .sr_out(sr_out), .pc_out(pc_out));
